// [dv/avalon_host.sv]
module avalon_host (
	input wire logic clk_i,
	input wire logic avs_waitrequest_i,
	output logic [clk_sel_pkg::ADDR_W-1:0] avs_address_o,
	output logic avs_read_o,
	output logic avs_write_o,
	output logic [clk_sel_pkg::DATA_W-1:0] avs_writedata_o,
	output logic [3:0] avs_byteenable_o,
	output logic decim_active_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import clk_sel_pkg::*;
	initial begin
		{avs_address_o, avs_read_o, avs_write_o, avs_writedata_o} = '0;
		avs_byteenable_o = 4'h0;
		decim_active_o = 1'b0;
	end
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [3:0] be);
		avs_address_o <= a;
		avs_writedata_o <= d;
		avs_byteenable_o <= be;
		avs_read_o <= !w;
		avs_write_o <= w;
		do @(posedge clk_i); while (avs_waitrequest_i);
		avs_read_o <= 1'b0;
		avs_write_o <= 1'b0;
		// released address and data never keep the old value
		avs_address_o <= ~a;
		avs_writedata_o <= ~d;
		@(posedge clk_i);
	endtask
endmodule

// [dv/clk_checker.sv]
module clk_checker (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [clk_sel_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [clk_sel_pkg::DATA_W-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic avs_waitrequest_o,
	input wire logic decim_active_i,
	input wire logic sample_from_pll_o,
	input wire logic dll_ref_from_ext_o,
	input wire logic dll_run_o,
	input wire logic dll_hold_reset_o,
	input wire logic dcc_active_o,
	input clk_sel_pkg::output_data_clock_src_t output_data_clock_src_o,
	input wire logic [clk_sel_pkg::PHASE_W-1:0] output_data_clock_phase_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import clk_sel_pkg::*;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	sequence req_open;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence soft_cmd;
		avs_write_i && !avs_waitrequest_o && avs_address_i == 10'h000
			&& avs_writedata_i[0] && avs_byteenable_i[0] && dll_run_o;
	endsequence
	// hold comes from the soft reset alone: loop running, reset bit clear
	sequence hold_run;
		##3 dll_hold_reset_o [*4] ##1 !dll_hold_reset_o;
	endsequence
	a_wait_first: assert property (req_open |=> !avs_waitrequest_o)
		else $error("waitrequest not low in second cycle");
	a_soft_hold: assert property (soft_cmd |-> hold_run)
		else $error("soft reset hold wrong");
	a_reset_state: assert property ($fell(sys_rst_i) |->
		dll_hold_reset_o && output_data_clock_src_o == OUTPUT_DATA_CLOCK_FROM_BUFFER && !sample_from_pll_o)
		else $error("wrong state after reset");
	a_decim_route: assert property (decim_active_i |=> output_data_clock_src_o == OUTPUT_DATA_CLOCK_FROM_DECIM)
		else $error("decimation not routed");
	a_src_excl: assert property (sample_from_pll_o ^ dll_ref_from_ext_o)
		else $error("source outputs inconsistent");
	a_dcc_loop: assert property (dcc_active_o |-> !sample_from_pll_o)
		else $error("correction with multiplier");
	a_run_hold: assert property (dll_run_o |-> !dll_hold_reset_o)
		else $error("loop runs in reset");
	a_buf_phase: assert property (output_data_clock_src_o == OUTPUT_DATA_CLOCK_FROM_BUFFER |->
		output_data_clock_phase_o == 3'h0)
		else $error("buffer clock phase nonzero");
	a_loop_phase: assert property (output_data_clock_src_o == OUTPUT_DATA_CLOCK_FROM_DLL |->
		output_data_clock_phase_o != 3'h0 && dll_ref_from_ext_o)
		else $error("loop clock route wrong");
endmodule

bind adc_clock_select_dll_control clk_checker u_chk (.*);

// [dv/tb_top.sv]
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import clk_sel_pkg::*;
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
	logic clk_i = 0;
	logic sys_rst_i = 1;
	logic [9:0] avs_address_i;
	logic avs_read_i, avs_write_i, avs_waitrequest_o, decim_active_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, e;
	logic [3:0] avs_byteenable_i;
	logic sample_from_pll_o, dll_ref_from_ext_o, dll_run_o, dll_hold_reset_o, dcc_active_o;
	logic [2:0] output_data_clock_phase_o;
	output_data_clock_src_t output_data_clock_src_o;
	int errors = 0;
	int compares = 0;
	int seed = 13457;
	logic [31:0] exp_q[$];
	always #10 clk_i = ~clk_i;
	avalon_host host (.clk_i, .avs_waitrequest_i(avs_waitrequest_o),
		.avs_address_o(avs_address_i), .avs_read_o(avs_read_i), .avs_write_o(avs_write_i),
		.avs_writedata_o(avs_writedata_i), .avs_byteenable_o(avs_byteenable_i),
		.decim_active_o(decim_active_i));
	adc_clock_select_dll_control DUT (.*);
	task automatic rd(input logic [9:0] a, input logic [31:0] x);
		exp_q.push_back(x);
		host.xfer(1'b0, a, $random(seed), 4'hF);
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] v, input logic [3:0] be = 4'h1);
		host.xfer(1'b1, a, {24'($random(seed)), v}, be);
	endtask
	task automatic stat(input logic [7:0] x);
		repeat (4) @(posedge clk_i);
		rd(10'h004, {24'h0, x});
	endtask
	always @(posedge clk_i) begin
		if (avs_read_i && !avs_waitrequest_o) begin
			e = exp_q.pop_front();
			`CHK("readdata", e, avs_readdata_o)
		end
	end
	task automatic conclude;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#(20 * 4000);
		errors++;
		conclude();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		rd(10'h148, 32'h08);
		rd(10'h14C, 32'h00);
		rd(10'h190, 32'h00);
		stat(8'h14);
		$display("reset values done");
		wr(10'h148, 8'hFF);
		wr(10'h149, 8'h00);
		wr(10'h148, 8'h00, 4'hE);
		rd(10'h148, 32'h7F);
		rd(10'h3FC, 32'h00);
		$display("register access done");
		wr(10'h148, 8'h35);
		stat(8'h22);
		`CHK("phase", 3'h3, output_data_clock_phase_o)
		wr(10'h148, 8'h37);
		stat(8'h2A);
		$display("delay loop done");
		wr(10'h14C, 8'h01);
		stat(8'h83);
		wr(10'h14C, 8'h00);
		$display("multiplier done");
		wr(10'h190, 8'h05);
		host.decim_active_o <= 1'b1;
		stat(8'h4A);
		`CHK("phase", 3'h5, output_data_clock_phase_o)
		host.decim_active_o <= 1'b0;
		$display("decimation done");
		wr(10'h148, 8'h3F);
		stat(8'h2C);
		wr(10'h000, 8'h01);
		repeat (6) @(posedge clk_i);
		rd(10'h148, 32'h37);
		wr(10'h000, 8'h01);
		repeat (6) @(posedge clk_i);
		stat(8'h2A);
		wr(10'h148, 8'h38);
		wr(10'h000, 8'h01);
		repeat (6) @(posedge clk_i);
		rd(10'h148, 32'h38);
		@(posedge clk_i);
		$display("soft reset done");
		conclude();
	end
endmodule

// [verilog/adc_clock_select_dll_control.sv]
// How it works
// - power-up times converter from external clock
// - source one uses internal multiplier clock
// - source zero takes clock from buffer
// - no loop, no decimation, source zero: buffer drives data clock
// - decimation block sets data clock rate, phase
// - decimation phase comes from its own field
// - source zero feeds external clock into loop
// - loop enable bit activates delay loop
// - three-bit field sets data clock phase
// - all bits set: correction and phase offered
// - correction moves falling edge only
// - correction only with loop, never multiplier
// - loop held in reset until bit cleared
// - soft reset with loop enabled resets loop, clears bit
module adc_clock_select_dll_control (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [clk_sel_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [clk_sel_pkg::DATA_W-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [clk_sel_pkg::DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic decim_active_i,
	output logic sample_from_pll_o,
	output logic dll_ref_from_ext_o,
	output logic dll_run_o,
	output logic dll_hold_reset_o,
	output logic dcc_active_o,
	output clk_sel_pkg::output_data_clock_src_t output_data_clock_src_o,
	output logic [clk_sel_pkg::PHASE_W-1:0] output_data_clock_phase_o
);
	import clk_sel_pkg::*;

	typedef struct packed {
		logic [7:0] delay_loop_control;
		logic [7:0] clock_source_config;
		logic [7:0] decimated_output_clock_phase;
		logic ack;
		logic soft_reset;
		logic [DATA_W-1:0] rdata;
		clk_route_t route;
	} state_t;

	state_t s_q;
	state_t s_d;
	clk_cfg_t cfg;
	clk_route_t route;
	logic seq_hold;
	logic seq_clear;
	logic [7:0] idx;
	logic aligned;
	logic wr_take;
	logic [7:0] wbyte;

	// ----------------------------------------
	// configuration view
	// ----------------------------------------
	always_comb begin
		cfg.dll_enable = s_q.delay_loop_control[DLC_ENABLE_BIT];
		cfg.duty_cycle_correction = s_q.delay_loop_control[DLC_DUTY_BIT];
		cfg.delay_loop_output_clock_enable = s_q.delay_loop_control[DLC_OUT_CLK_EN_BIT];
		cfg.dll_reset = s_q.delay_loop_control[DLC_RESET_BIT];
		cfg.output_phase_delay_control = s_q.delay_loop_control[DLC_PHASE_LSB +: PHASE_W];
		cfg.clock_source = s_q.clock_source_config[CSC_SOURCE_BIT];
		cfg.decimation_clock_phase_delay =
			s_q.decimated_output_clock_phase[DEC_PHASE_LSB +: PHASE_W];
		cfg.decim_active = decim_active_i;
	end

	dll_reset_seq u_seq (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.soft_reset_i(s_q.soft_reset),
		.dll_enable_i(cfg.dll_enable),
		.hold_o(seq_hold),
		.clear_bit_o(seq_clear)
	);

	clk_route u_route (
		.cfg_i(cfg),
		.seq_hold_i(seq_hold),
		.route_o(route)
	);

	// ----------------------------------------
	// bus slave and register file
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		idx = avs_address_i[9:2];
		aligned = (avs_address_i[1:0] == 2'h0);
		wr_take = avs_write_i && s_q.ack && aligned && avs_byteenable_i[0];
		wbyte = avs_writedata_i[7:0];
		s_d.ack = (avs_read_i || avs_write_i) && !s_q.ack;
		s_d.soft_reset = 1'b0;
		s_d.route = route;
		if (avs_read_i && !s_q.ack) begin
			s_d.rdata = '0;
			if (aligned) begin
				case (idx)
					IDX_DELAY_LOOP_CONTROL: s_d.rdata[7:0] = s_q.delay_loop_control;
					IDX_CLOCK_SOURCE_CONFIG: s_d.rdata[7:0] = s_q.clock_source_config;
					IDX_DECIMATED_OUTPUT_CLOCK_PHASE: begin
						s_d.rdata[7:0] = s_q.decimated_output_clock_phase;
					end
					IDX_STATUS: begin
						s_d.rdata[7:0] = {output_data_clock_src_o, dcc_active_o, dll_hold_reset_o,
							dll_run_o, sample_from_pll_o};
					end
					default: s_d.rdata = '0;
				endcase
			end
		end
		// loop reset bit self-clears at the end of a soft-reset hold
		if (seq_clear) begin
			s_d.delay_loop_control[DLC_RESET_BIT] = 1'b0;
		end
		if (wr_take) begin
			case (idx)
				IDX_DELAY_LOOP_CONTROL: s_d.delay_loop_control = {1'b0, wbyte[6:0]};
				IDX_CLOCK_SOURCE_CONFIG: begin
					s_d.clock_source_config = {7'h00, wbyte[CSC_SOURCE_BIT]};
				end
				IDX_DECIMATED_OUTPUT_CLOCK_PHASE: begin
					s_d.decimated_output_clock_phase = {5'h00, wbyte[PHASE_W-1:0]};
				end
				IDX_COMMAND: s_d.soft_reset = wbyte[CMD_SOFT_RESET_BIT];
				default: s_d.soft_reset = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_q.delay_loop_control <= DLC_RESET_VAL;
			s_q.clock_source_config <= CSC_RESET_VAL;
			s_q.decimated_output_clock_phase <= DEC_RESET_VAL;
			s_q.ack <= 1'b0;
			s_q.soft_reset <= 1'b0;
			s_q.rdata <= '0;
			s_q.route <= '{sample_from_pll: 1'b0, dll_ref_from_ext: 1'b1, dll_run: 1'b0,
				dll_hold_reset: 1'b1, dcc_active: 1'b0, output_data_clock_src: OUTPUT_DATA_CLOCK_FROM_BUFFER,
				output_data_clock_phase: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s_q.ack;
	assign avs_readdata_o = s_q.rdata;
	assign sample_from_pll_o = s_q.route.sample_from_pll;
	assign dll_ref_from_ext_o = s_q.route.dll_ref_from_ext;
	assign dll_run_o = s_q.route.dll_run;
	assign dll_hold_reset_o = s_q.route.dll_hold_reset;
	assign dcc_active_o = s_q.route.dcc_active;
	assign output_data_clock_src_o = s_q.route.output_data_clock_src;
	assign output_data_clock_phase_o = s_q.route.output_data_clock_phase;

endmodule

// [verilog/clk_route.sv]
module clk_route (
	input clk_sel_pkg::clk_cfg_t cfg_i,
	input wire logic seq_hold_i,
	output clk_sel_pkg::clk_route_t route_o
);
	import clk_sel_pkg::*;

	logic phase_ctl;
	logic dll_out_used;

	always_comb begin
		phase_ctl = (cfg_i.output_phase_delay_control != '0);
		dll_out_used = cfg_i.dll_enable && cfg_i.delay_loop_output_clock_enable && phase_ctl
			&& !cfg_i.clock_source;
		route_o.sample_from_pll = cfg_i.clock_source;
		route_o.dll_ref_from_ext = !cfg_i.clock_source;
		route_o.dll_run = cfg_i.dll_enable && !cfg_i.dll_reset && !seq_hold_i;
		route_o.dll_hold_reset = cfg_i.dll_reset || seq_hold_i;
		// correction never on the multiplier clock
		route_o.dcc_active = cfg_i.duty_cycle_correction && cfg_i.dll_enable
			&& !cfg_i.clock_source;
		if (cfg_i.decim_active) begin
			route_o.output_data_clock_src = OUTPUT_DATA_CLOCK_FROM_DECIM;
			route_o.output_data_clock_phase = cfg_i.decimation_clock_phase_delay;
		end else if (dll_out_used) begin
			route_o.output_data_clock_src = OUTPUT_DATA_CLOCK_FROM_DLL;
			route_o.output_data_clock_phase = cfg_i.output_phase_delay_control;
		end else if (cfg_i.clock_source) begin
			route_o.output_data_clock_src = OUTPUT_DATA_CLOCK_FROM_PLL;
			route_o.output_data_clock_phase = '0;
		end else begin
			route_o.output_data_clock_src = OUTPUT_DATA_CLOCK_FROM_BUFFER;
			route_o.output_data_clock_phase = '0;
		end
	end

endmodule

// [verilog/clk_sel_pkg.sv]
package clk_sel_pkg;

	// ----------------------------------------
	// bus and timing
	// ----------------------------------------
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int CLK_PERIOD_NS = 20;
	localparam int DLL_SOFT_RST_NS = 80;
	localparam int DLL_SOFT_RST_CYC = (DLL_SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;

	// ----------------------------------------
	// register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [7:0] IDX_COMMAND = 8'h00;
	localparam logic [7:0] IDX_STATUS = 8'h01;
	localparam logic [7:0] IDX_DELAY_LOOP_CONTROL = 8'h52;
	localparam logic [7:0] IDX_CLOCK_SOURCE_CONFIG = 8'h53;
	localparam logic [7:0] IDX_DECIMATED_OUTPUT_CLOCK_PHASE = 8'h64;

	// ----------------------------------------
	// delay_loop_control fields
	// ----------------------------------------
	localparam int DLC_ENABLE_BIT = 0;
	localparam int DLC_DUTY_BIT = 1;
	localparam int DLC_OUT_CLK_EN_BIT = 2;
	localparam int DLC_RESET_BIT = 3;
	localparam int DLC_PHASE_LSB = 4;
	localparam int PHASE_W = 3;
	localparam logic [7:0] DLC_RESET_VAL = 8'h08;

	// ----------------------------------------
	// other fields
	// ----------------------------------------
	localparam int CSC_SOURCE_BIT = 0;
	localparam logic [7:0] CSC_RESET_VAL = 8'h00;
	localparam int DEC_PHASE_LSB = 0;
	localparam logic [7:0] DEC_RESET_VAL = 8'h00;
	localparam int CMD_SOFT_RESET_BIT = 0;

	// ----------------------------------------
	// clock routing choices
	// ----------------------------------------
	typedef enum logic [3:0] {
		OUTPUT_DATA_CLOCK_FROM_BUFFER = 4'h1,
		OUTPUT_DATA_CLOCK_FROM_DLL = 4'h2,
		OUTPUT_DATA_CLOCK_FROM_DECIM = 4'h4,
		OUTPUT_DATA_CLOCK_FROM_PLL = 4'h8
	} output_data_clock_src_t;

	typedef struct packed {
		logic dll_enable;
		logic duty_cycle_correction;
		logic delay_loop_output_clock_enable;
		logic dll_reset;
		logic [PHASE_W-1:0] output_phase_delay_control;
		logic clock_source;
		logic [PHASE_W-1:0] decimation_clock_phase_delay;
		logic decim_active;
	} clk_cfg_t;

	typedef struct packed {
		logic sample_from_pll;
		logic dll_ref_from_ext;
		logic dll_run;
		logic dll_hold_reset;
		logic dcc_active;
		output_data_clock_src_t output_data_clock_src;
		logic [PHASE_W-1:0] output_data_clock_phase;
	} clk_route_t;

endpackage

// [verilog/dll_reset_seq.sv]
module dll_reset_seq (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic soft_reset_i,
	input wire logic dll_enable_i,
	output logic hold_o,
	output logic clear_bit_o
);
	import clk_sel_pkg::*;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'h1,
		SEQ_HOLD = 2'h2
	} seq_state_t;

	typedef struct packed {
		seq_state_t state;
		logic [CNT_W-1:0] cnt;
		logic done;
	} seq_t;

	seq_t s_q;
	seq_t s_d;

	// ----------------------------------------
	// timed delay-loop reset after soft reset
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		case (s_q.state)
			SEQ_IDLE: begin
				if (soft_reset_i && dll_enable_i) begin
					s_d.state = SEQ_HOLD;
					s_d.cnt = CNT_W'(DLL_SOFT_RST_CYC - 1);
				end
			end
			SEQ_HOLD: begin
				if (s_q.cnt == '0) begin
					s_d.state = SEQ_IDLE;
					s_d.done = 1'b1;
				end else begin
					s_d.cnt = s_q.cnt - CNT_W'(1);
				end
			end
			default: begin
				s_d.state = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_q <= '{state: SEQ_IDLE, cnt: '0, done: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign hold_o = (s_q.state == SEQ_HOLD);
	assign clear_bit_o = s_q.done;

endmodule
